// ==== cal_divider.sv ====
`timescale 1ns/1ps
module cal_divider
  import pm_pkg::*;
#(
  parameter int HALF0 = CAL_HALF_0,
  parameter int HALF1 = CAL_HALF_1,
  parameter int HALF2 = CAL_HALF_2,
  parameter int HALF3 = CAL_HALF_3
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] sel_i,
  input wire logic en_i,
  output logic wave_o
);
  logic [31:0] cnt_ff;
  logic [31:0] half;

  always_comb begin
    case (sel_i)
      2'h0: half = 32'(HALF0);
      2'h1: half = 32'(HALF1);
      2'h2: half = 32'(HALF2);
      default: half = 32'(HALF3);
    endcase
  end

  // Restart on disable so the first edge is a full half period
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= 32'h0;
      wave_o <= 1'b0;
    end else if (!en_i) begin
      cnt_ff <= 32'h0;
      wave_o <= 1'b0;
    end else if (cnt_ff >= half - 32'h1) begin
      cnt_ff <= 32'h0;
      wave_o <= ~wave_o;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end
endmodule

// ==== pm_core_ctrl.sv ====
`timescale 1ns/1ps
module pm_core_ctrl
  import pm_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Power-saving interrupt from the device
  input wire logic POWER_SAVING_IRQ_I,
  // Controller interrupt
  output logic IRQ_O,
  // Register access port
  sfr_if.core SFR
);
  logic [7:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] rdata_ff;
  logic [1:0] irq_en_ff;
  logic [1:0] irq_st_ff;
  logic [1:0] rd_pipe_ff;
  logic busy_ff;
  logic saving_q_ff;
  logic wb_req;
  logic wb_wr;
  logic cmd_go;
  logic [1:0] ev;

  assign wb_req = CYC_I && STB_I && !ACK_O;
  assign wb_wr = wb_req && WE_I && SEL_I[0];

  // ------------------------------------------------------------
  // Bus slave, one wait state
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0;
    end else begin
      ACK_O <= wb_req;
      if (wb_req && !WE_I) begin
        case (ADR_I)
          CTL_ADDR: DAT_O <= {24'h0, addr_ff};
          CTL_WDATA: DAT_O <= {24'h0, wdata_ff};
          CTL_STATUS: DAT_O <= {22'h0, irq_st_ff, 7'h0, busy_ff};
          CTL_RDATA: DAT_O <= {24'h0, rdata_ff};
          default: DAT_O <= 32'h0;
        endcase
      end
    end
  end

  // Enables sit in byte 1, so they follow that lane, not the byte-0 lane
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      irq_en_ff <= 2'h0;
    end else begin
      if (wb_wr) begin
        case (ADR_I)
          CTL_ADDR: addr_ff <= DAT_I[7:0];
          CTL_WDATA: wdata_ff <= DAT_I[7:0];
          default: ;
        endcase
      end
      if (wb_req && WE_I && SEL_I[1] && ADR_I == CTL_STATUS) begin
        irq_en_ff <= DAT_I[9:8];
      end
    end
  end

  assign cmd_go = wb_wr && ADR_I == CTL_CMD && !busy_ff;

  // ------------------------------------------------------------
  // Register access strobes
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      SFR.wr <= 1'b0;
      SFR.rd <= 1'b0;
      SFR.bit_wr <= 1'b0;
      SFR.bit_sel <= 3'h0;
      SFR.bit_val <= 1'b0;
      SFR.addr <= 8'h00;
      SFR.wdata <= 8'h00;
      rd_pipe_ff <= 2'h0;
      busy_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      SFR.wr <= cmd_go && DAT_I[CMD_WRITE_BIT];
      SFR.rd <= cmd_go && DAT_I[CMD_READ_BIT];
      SFR.bit_wr <= cmd_go && DAT_I[CMD_BITOP_BIT];
      if (cmd_go) begin
        SFR.addr <= addr_ff;
        SFR.wdata <= wdata_ff;
        SFR.bit_val <= DAT_I[CMD_BITVAL_BIT];
        SFR.bit_sel <= DAT_I[CMD_BITSEL_LSB +: 3];
      end
      rd_pipe_ff <= {rd_pipe_ff[0], cmd_go};
      if (cmd_go) begin
        busy_ff <= 1'b1;
      end else if (rd_pipe_ff[1]) begin
        busy_ff <= 1'b0;
        rdata_ff <= SFR.rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt status, set wins over clear
  // ------------------------------------------------------------
  assign ev[IRQ_DONE_BIT] = rd_pipe_ff[1];
  assign ev[IRQ_POWER_SAVING_BIT] = POWER_SAVING_IRQ_I && !saving_q_ff;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      saving_q_ff <= 1'b0;
      irq_st_ff <= 2'h0;
    end else begin
      saving_q_ff <= POWER_SAVING_IRQ_I;
      if (wb_req && WE_I && SEL_I[1] && ADR_I == CTL_IRQ_CLEAR) begin
        irq_st_ff <= (irq_st_ff & ~DAT_I[9:8]) | ev;
      end else begin
        irq_st_ff <= irq_st_ff | ev;
      end
    end
  end

  assign IRQ_O = |(irq_st_ff & irq_en_ff);
endmodule

// ==== pm_link_monitor.sv ====
`timescale 1ns/1ps
module pm_link_monitor
  import pm_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Register link
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic bit_wr,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  // ----------------------------------------
  // Shadow copies of the key, protected and plain registers
  // ----------------------------------------
  logic [7:0] key_ff;
  logic [7:0] pin_ff;
  logic [7:0] en_ff;
  logic [7:0] sw_ff;
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) key_ff <= RST_ZERO;
    else if (wr && addr == ADDR_WRITE_KEY) key_ff <= wdata;
  end
  // Bit 4 reads back as zero
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) pin_ff <= RST_ZERO;
    else if (wr && addr == ADDR_IRQ_PIN_CAL && key_ff == UNLOCK_KEY) pin_ff <= wdata & 8'hef;
  end
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) en_ff <= RST_ZERO;
    else if (wr && addr == ADDR_SUPPLY_IRQ_ENABLE) en_ff <= wdata;
  end
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) sw_ff <= RST_ZERO;
    else if (wr && addr == ADDR_SWITCHOVER_CONFIG) sw_ff <= wdata;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  strobe_spacing_a: assert property ((wr || rd || bit_wr) |=> !(wr || rd || bit_wr) [*2])
    else $error("link strobes too close");
  strobe_onehot_a: assert property ($onehot0({wr, rd, bit_wr}))
    else $error("two link strobes at once");
  rdata_hold_a: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
  key_readback_a: assert property (rd && addr == ADDR_WRITE_KEY |=> rdata == key_ff)
    else $error("key register readback wrong");
  pin_key_lock_a: assert property (rd && addr == ADDR_IRQ_PIN_CAL |=> rdata == pin_ff)
    else $error("pin config write protection wrong");
  flag_reserved_a: assert property (rd && addr == ADDR_SUPPLY_EVENT_FLAGS |=> !rdata[4])
    else $error("reserved flag bit read as one");
  enable_read_a: assert property (rd && addr == ADDR_SUPPLY_IRQ_ENABLE |=> rdata == en_ff)
    else $error("enable register readback wrong");
  policy_read_a: assert property (rd && addr == ADDR_SWITCHOVER_CONFIG |=> rdata == sw_ff)
    else $error("switchover register readback wrong");
endmodule

// ==== pm_pkg.sv ====
package pm_pkg;
  // ------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'hc5;
  localparam logic [7:0] ADDR_WRITE_KEY = 8'hc1;
  localparam logic [7:0] ADDR_SUPPLY_IRQ_ENABLE = 8'hec;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIG = 8'hf4;
  localparam logic [7:0] ADDR_SWITCHOVER_CONFIG = 8'hf5;
  localparam logic [7:0] ADDR_SUPPLY_EVENT_FLAGS = 8'hf8;
  localparam logic [7:0] ADDR_SCRATCH_ONE = 8'hfb;
  localparam logic [7:0] ADDR_SCRATCH_TWO = 8'hfc;
  localparam logic [7:0] ADDR_SCRATCH_THREE = 8'hfd;
  localparam logic [7:0] ADDR_SCRATCH_FOUR = 8'hfe;
  localparam logic [7:0] ADDR_IRQ_PIN_CAL = 8'hff;
  // ------------------------------------------------------------
  // Key and field positions
  // ------------------------------------------------------------
  localparam logic [7:0] UNLOCK_KEY = 8'hea;
  localparam logic [7:0] LOCK_KEY = 8'h00;
  localparam int CAL_OUT_EN_BIT = 7;
  localparam int CAL_SEL_LSB = 5;
  localparam int EXT1_FN_LSB = 1;
  localparam int EXT0_FN_BIT = 0;
  localparam int FLAG_RESTORED = 7;
  localparam int FLAG_POWER_SAVING = 6;
  localparam int FLAG_SAG = 5;
  localparam int FLAG_RESERVED = 4;
  localparam int FLAG_DC_ADC = 3;
  localparam int FLAG_BATTERY = 2;
  localparam int FLAG_TO_BATTERY = 1;
  localparam int FLAG_DC_LOW = 0;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_CONFIG = 8'h60;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h80;
  // Event bits of the flag layout (bit 6 is the summary, bit 4 reserved)
  localparam logic [7:0] EVENT_MASK = 8'haf;
  // ------------------------------------------------------------
  // Host controller registers (Wishbone byte offsets)
  // ------------------------------------------------------------
  localparam logic [3:0] CTL_ADDR = 4'h0;
  localparam logic [3:0] CTL_WDATA = 4'h4;
  localparam logic [3:0] CTL_CMD = 4'h8;
  localparam logic [3:0] CTL_STATUS = 4'hc;
  localparam logic [3:0] CTL_IRQ_ENABLE = 4'h0;
  localparam logic [3:0] CTL_IRQ_CLEAR = 4'h4;
  localparam logic [3:0] CTL_RDATA = 4'h8;
  localparam logic [3:0] CTL_IRQ_STATUS = 4'hc;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_BITOP_BIT = 2;
  localparam int CMD_BITVAL_BIT = 3;
  localparam int CMD_BITSEL_LSB = 4;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_POWER_SAVING_BIT = 1;
  // Calibration half periods in 10 ns cycles: 1 Hz, 512 Hz, 500 Hz, 16 kHz
  localparam int CLK_HZ = 100000000;
  localparam int CAL_HZ_0 = 1;
  localparam int CAL_HZ_1 = 512;
  localparam int CAL_HZ_2 = 500;
  localparam int CAL_HZ_3 = 16384;
  localparam int CAL_HALF_0 = CLK_HZ / (2 * CAL_HZ_0);
  localparam int CAL_HALF_1 = CLK_HZ / (2 * CAL_HZ_1);
  localparam int CAL_HALF_2 = CLK_HZ / (2 * CAL_HZ_2);
  localparam int CAL_HALF_3 = CLK_HZ / (2 * CAL_HZ_3);
endpackage

// ==== power_mgmt_registers.sv ====
`timescale 1ns/1ps
// Functional notes
// R1 - cal select: 1Hz,512Hz,500Hz,16kHz outputs
// R2 - bit 7 drives calibration output pin
// R3 - ext irq one field: function, enable
// R4 - bit 0 enables ext irq zero
// R5 - config writes need key 0xea
// R6 - software relocks key to zero afterwards
// R7 - flag 7: supply restored from battery
// R8 - flag 6: any enabled event summary
// R9 - flag 5: voltage sag
// R10 - flag 3: dc input change or ready
// R11 - flag 2: battery low or ready
// R12 - flag 1: switched to battery
// R13 - flag 0: dc input below 1.2V
// R14 - reserved flag bit 4 kept zero
// R15 - switchover policy decode
// R16 - switchover bits 7:2 kept zero (the register stores and reads back all eight bits)
// R17 - enables gate summary, same layout
// R18 - sticky flags, cleared by writing zero
module power_mgmt_registers
  import pm_pkg::*;
#(
  parameter int HALF0 = CAL_HALF_0,
  parameter int HALF1 = CAL_HALF_1,
  parameter int HALF2 = CAL_HALF_2,
  parameter int HALF3 = CAL_HALF_3
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Register access
  sfr_if.device SFR,
  // Supply event sources, one-cycle pulses
  input wire logic TO_MAIN_I,
  input wire logic TO_BATTERY_I,
  input wire logic SAG_I,
  input wire logic DC_ADC_EVENT_I,
  input wire logic BATTERY_EVENT_I,
  input wire logic DC_LOW_I,
  // Pin functions
  output logic CAL_OUT_O,
  output logic CAL_OUT_OE_O,
  output logic EXT1_GPIO_O,
  output logic EXT1_BATTERY_CONTROL_O,
  output logic EXT1_IRQ_EN_O,
  output logic EXT0_IRQ_EN_O,
  // Switchover policy
  output logic SWITCH_ON_LOW_MAIN_O,
  output logic SWITCH_ON_LOW_DC_O,
  // Summary interrupt
  output logic POWER_SAVING_IRQ_O
);
  logic [7:0] key_ff;
  logic [7:0] pin_cfg_ff;
  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;
  logic [7:0] irq_en_ff;
  logic [7:0] switch_cfg_ff;
  logic [7:0] peripheral_ff;
  logic [7:0] power_ff;
  logic [7:0] scratch_ff [4];
  logic [7:0] events;
  logic cal_wave;

  // ------------------------------------------------------------
  // Key and protected configuration
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      key_ff <= LOCK_KEY;
    end else if (SFR.wr && SFR.addr == ADDR_WRITE_KEY) begin
      key_ff <= SFR.wdata; // see R6
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pin_cfg_ff <= RST_ZERO;
    end else if (SFR.wr && SFR.addr == ADDR_IRQ_PIN_CAL && key_ff == UNLOCK_KEY) begin
      pin_cfg_ff <= SFR.wdata; // see R5
    end
  end

  // ------------------------------------------------------------
  // Plain read/write registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      irq_en_ff <= RST_ZERO;
      switch_cfg_ff <= RST_ZERO;
      peripheral_ff <= RST_PERIPHERAL_CONFIG;
      power_ff <= RST_POWER_CONTROL;
    end else if (SFR.wr) begin
      case (SFR.addr)
        ADDR_SUPPLY_IRQ_ENABLE: irq_en_ff <= SFR.wdata;
        ADDR_SWITCHOVER_CONFIG: switch_cfg_ff <= SFR.wdata;
        ADDR_PERIPHERAL_CONFIG: peripheral_ff <= SFR.wdata;
        ADDR_POWER_CONTROL: power_ff <= SFR.wdata;
        default: ;
      endcase
    end
  end

  // Scratch pads survive device reset; only power loss clears them
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_scratch
      always_ff @(posedge CLK_I) begin
        if (SFR.wr && SFR.addr == ADDR_SCRATCH_ONE + 8'(gi)) begin
          scratch_ff[gi] <= SFR.wdata;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Sticky supply flags
  // ------------------------------------------------------------
  always_comb begin
    events = 8'h00;
    events[FLAG_RESTORED] = TO_MAIN_I; // see R7
    events[FLAG_SAG] = SAG_I; // see R9
    events[FLAG_DC_ADC] = DC_ADC_EVENT_I; // see R10
    events[FLAG_BATTERY] = BATTERY_EVENT_I; // see R11
    events[FLAG_TO_BATTERY] = TO_BATTERY_I; // see R12
    events[FLAG_DC_LOW] = DC_LOW_I; // see R13
  end

  always_comb begin
    nxt_flags = flags_ff;
    if (SFR.wr && SFR.addr == ADDR_SUPPLY_EVENT_FLAGS) begin
      nxt_flags = flags_ff & SFR.wdata; // see R18
    end else if (SFR.bit_wr && !SFR.bit_val) begin
      nxt_flags[SFR.bit_sel] = 1'b0; // see R18
    end
    // Set beats a same-cycle clear so no event is lost
    nxt_flags = nxt_flags | (events & EVENT_MASK);
    // Summary is set by any enabled event, live or already flagged
    if (|(irq_en_ff & EVENT_MASK & (events | flags_ff))) begin
      nxt_flags[FLAG_POWER_SAVING] = 1'b1; // see R8, R17
    end
    nxt_flags[FLAG_RESERVED] = 1'b0; // see R14
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      flags_ff <= RST_ZERO;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign POWER_SAVING_IRQ_O = flags_ff[FLAG_POWER_SAVING];

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      SFR.rdata <= 8'h00;
    end else if (SFR.rd) begin
      case (SFR.addr)
        ADDR_WRITE_KEY: SFR.rdata <= key_ff;
        ADDR_IRQ_PIN_CAL: SFR.rdata <= pin_cfg_ff & 8'hef;
        ADDR_SUPPLY_EVENT_FLAGS: SFR.rdata <= flags_ff;
        ADDR_SUPPLY_IRQ_ENABLE: SFR.rdata <= irq_en_ff;
        ADDR_SWITCHOVER_CONFIG: SFR.rdata <= switch_cfg_ff;
        ADDR_PERIPHERAL_CONFIG: SFR.rdata <= peripheral_ff;
        ADDR_POWER_CONTROL: SFR.rdata <= power_ff;
        ADDR_SCRATCH_ONE: SFR.rdata <= scratch_ff[0];
        ADDR_SCRATCH_TWO: SFR.rdata <= scratch_ff[1];
        ADDR_SCRATCH_THREE: SFR.rdata <= scratch_ff[2];
        ADDR_SCRATCH_FOUR: SFR.rdata <= scratch_ff[3];
        default: SFR.rdata <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin functions
  // ------------------------------------------------------------
  cal_divider #(
    .HALF0(HALF0),
    .HALF1(HALF1),
    .HALF2(HALF2),
    .HALF3(HALF3)
  ) u_cal (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .sel_i(pin_cfg_ff[CAL_SEL_LSB +: 2]), // see R1
    .en_i(pin_cfg_ff[CAL_OUT_EN_BIT]),
    .wave_o(cal_wave)
  );

  assign CAL_OUT_O = cal_wave;
  assign CAL_OUT_OE_O = pin_cfg_ff[CAL_OUT_EN_BIT]; // see R2

  logic [2:0] ext1_fn;
  assign ext1_fn = pin_cfg_ff[EXT1_FN_LSB +: 3];
  assign EXT1_GPIO_O = ext1_fn[1:0] == 2'h0; // see R3
  assign EXT1_BATTERY_CONTROL_O = ext1_fn[1:0] == 2'h1; // see R3
  assign EXT1_IRQ_EN_O = ext1_fn[2:1] == 2'h3; // see R3
  assign EXT0_IRQ_EN_O = pin_cfg_ff[EXT0_FN_BIT]; // see R4

  assign SWITCH_ON_LOW_MAIN_O = !switch_cfg_ff[1]; // see R15
  assign SWITCH_ON_LOW_DC_O = switch_cfg_ff[1:0] == 2'h1; // see R15
endmodule

// ==== power_mgmt_registers_test.sv ====
`timescale 1ns/1ps
module power_mgmt_registers_test;
  import pm_pkg::*;
  // ----------------------------------------
  // Stimulus and wiring
  // ----------------------------------------
  localparam int HV [4] = '{8, 6, 5, 4};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [5:0] ev = 6'h00;
  wire logic [31:0] dat_r;
  wire logic ack;
  wire logic irq;
  wire logic cal;
  wire logic [7:0] pins;
  logic [31:0] t;
  logic [7:0] q;
  logic p;
  int n;
  int err_total = 0;
  int n_tests = 0;
  int fbit [6] = '{7, 1, 5, 3, 2, 0};
  logic [7:0] ra [7] = '{ADDR_SUPPLY_EVENT_FLAGS, ADDR_SUPPLY_IRQ_ENABLE,
    ADDR_SWITCHOVER_CONFIG, ADDR_IRQ_PIN_CAL, ADDR_PERIPHERAL_CONFIG, ADDR_POWER_CONTROL,
    ADDR_WRITE_KEY};
  logic [7:0] rv [7] = '{RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_PERIPHERAL_CONFIG,
    RST_POWER_CONTROL, RST_ZERO};
  always #5 clk = ~clk;
  sfr_if bus ();
  pm_core_ctrl u_pm_core_ctrl (.CLK_I(clk), .NRST_I(nrst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .POWER_SAVING_IRQ_I(pins[6]), .IRQ_O(irq), .SFR(bus));
  // Short half periods keep the calibration run brief
  power_mgmt_registers #(.HALF0(HV[0]), .HALF1(HV[1]), .HALF2(HV[2]), .HALF3(HV[3]))
    u_power_mgmt_registers (.CLK_I(clk), .NRST_I(nrst), .SFR(bus), .TO_MAIN_I(ev[0]),
    .TO_BATTERY_I(ev[1]), .SAG_I(ev[2]), .DC_ADC_EVENT_I(ev[3]), .BATTERY_EVENT_I(ev[4]),
    .DC_LOW_I(ev[5]), .CAL_OUT_O(cal), .CAL_OUT_OE_O(pins[7]), .EXT1_GPIO_O(pins[0]),
    .EXT1_BATTERY_CONTROL_O(pins[1]), .EXT1_IRQ_EN_O(pins[2]), .EXT0_IRQ_EN_O(pins[3]),
    .SWITCH_ON_LOW_MAIN_O(pins[4]), .SWITCH_ON_LOW_DC_O(pins[5]), .POWER_SAVING_IRQ_O(pins[6]));
  pm_link_monitor u_pm_link_monitor (.CLK_I(clk), .NRST_I(nrst), .addr(bus.addr), .wr(bus.wr),
    .rd(bus.rd), .bit_wr(bus.bit_wr), .bit_sel(bus.bit_sel), .bit_val(bus.bit_val),
    .wdata(bus.wdata), .rdata(bus.rdata));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input logic bad);
    if (bad !== 1'b0) begin
      chk("wait bound", 8'h00, 8'h01);
      complete_run();
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
      input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_w <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    tmo(ack !== 1'b1);
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic op(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
    int k;
    wb(1'b1, CTL_ADDR, 4'h1, {24'h0, a}, t);
    wb(1'b1, CTL_WDATA, 4'h1, {24'h0, d}, t);
    wb(1'b1, CTL_CMD, 4'h1, {24'h0, c}, t);
    k = 0;
    do begin
      wb(1'b0, CTL_STATUS, 4'hf, 32'h0, t);
      k++;
    end while (t[0] !== 1'b0 && k < 20);
    tmo(t[0]);
    wb(1'b0, CTL_RDATA, 4'hf, 32'h0, t);
    q = t[7:0];
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    op(a, 8'h00, 8'h02);
    chk(nm, e, q);
  endtask
  task automatic kw(input logic [7:0] d);
    op(ADDR_WRITE_KEY, UNLOCK_KEY, 8'h01);
    op(ADDR_IRQ_PIN_CAL, d, 8'h01);
    op(ADDR_WRITE_KEY, LOCK_KEY, 8'h01);
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ichk(input string nm, input logic e);
    repeat (2) @(posedge clk);
    chk(nm, {7'h0, e}, {7'h0, irq});
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("reset pins", 8'h11, pins);
    for (int i = 0; i < 7; i++) rchk("reset reg", ra[i], rv[i]);
    wb(1'b0, 4'h2, 4'hf, 32'h0, t);
    chk("unmapped", 8'h00, t[7:0] | t[15:8] | t[23:16] | t[31:24]);
    wb(1'b0, CTL_ADDR, 4'hf, 32'h0, t);
    chk("ctl addr", ADDR_WRITE_KEY, t[7:0]);
    op(ADDR_IRQ_PIN_CAL, 8'hff, 8'h01);
    rchk("locked", ADDR_IRQ_PIN_CAL, 8'h00);
    kw(8'hff);
    rchk("unlocked", ADDR_IRQ_PIN_CAL, 8'hef);
    chk("pins on", 8'h9c, pins);
    op(ADDR_IRQ_PIN_CAL, 8'h00, 8'h01);
    rchk("relocked", ADDR_IRQ_PIN_CAL, 8'hef);
    for (logic [3:0] f = 0; f < 8; f++) begin
      kw({4'h0, f[2:0], 1'b0});
      chk("ext one", {5'h02, f[2:1] == 2'b11, f[1:0] == 2'b01, f[1:0] == 2'b00}, pins);
    end
    for (logic [2:0] s = 0; s < 4; s++) begin
      kw({1'b1, s[1:0], 5'h00});
      // Third interval is clear of any divider restart
      for (int j = 0; j < 3; j++) begin
        p = cal;
        n = 0;
        do begin
          @(posedge clk);
          n++;
        end while (cal === p && n < 40);
        tmo(n >= 40);
      end
      chk("cal half", 8'(HV[s]), 8'(n));
    end
    for (logic [2:0] v = 0; v < 4; v++) begin
      op(ADDR_SWITCHOVER_CONFIG, {6'h0, v[1:0]}, 8'h01);
      rchk("policy reg", ADDR_SWITCHOVER_CONFIG, {6'h0, v[1:0]});
      chk("policy pins", {6'h0, v[1:0] == 2'b01, !v[1]}, {6'h0, pins[5:4]});
    end
    for (int k = 0; k < 6; k++) begin
      pulse(k);
      rchk("flag", ADDR_SUPPLY_EVENT_FLAGS, 8'h01 << fbit[k]);
      op(ADDR_SUPPLY_EVENT_FLAGS, 8'h00, 8'h01);
      rchk("flag clr", ADDR_SUPPLY_EVENT_FLAGS, 8'h00);
    end
    op(ADDR_SUPPLY_IRQ_ENABLE, 8'h02, 8'h01);
    rchk("enable", ADDR_SUPPLY_IRQ_ENABLE, 8'h02);
    wb(1'b1, CTL_STATUS, 4'h2, 32'h200, t);
    pulse(1);
    pulse(2);
    rchk("summary", ADDR_SUPPLY_EVENT_FLAGS, 8'h62);
    chk("summary out", 8'h01, {7'h0, pins[6]});
    ichk("ctl irq", 1'b1);
    op(ADDR_SUPPLY_EVENT_FLAGS, 8'h00, 8'h54);
    rchk("bit clr", ADDR_SUPPLY_EVENT_FLAGS, 8'h42);
    op(ADDR_SUPPLY_EVENT_FLAGS, 8'h00, 8'h3c);
    rchk("bit one", ADDR_SUPPLY_EVENT_FLAGS, 8'h42);
    wb(1'b1, CTL_WDATA, 4'h2, 32'h200, t);
    ichk("irq clr", 1'b0);
    op(ADDR_SUPPLY_IRQ_ENABLE, 8'h00, 8'h01);
    op(ADDR_SUPPLY_EVENT_FLAGS, 8'h00, 8'h01);
    op(ADDR_SUPPLY_EVENT_FLAGS, 8'h00, 8'h01);
    rchk("flags off", ADDR_SUPPLY_EVENT_FLAGS, 8'h00);
    chk("summary off", 8'h00, {7'h0, pins[6]});
    wb(1'b1, CTL_STATUS, 4'h2, 32'h300, t);
    ichk("done irq", 1'b1);
    wb(1'b0, CTL_STATUS, 4'hf, 32'h0, t);
    chk("irq status", 8'h01, {6'h0, t[9:8]});
    wb(1'b1, CTL_WDATA, 4'h2, 32'h300, t);
    ichk("done clr", 1'b0);
    wb(1'b1, CTL_STATUS, 4'h2, 32'h0, t);
    for (int i = 0; i < 4; i++) op(8'(ADDR_SCRATCH_ONE + i), 8'(8'h3c ^ i), 8'h01);
    for (int i = 0; i < 4; i++) rchk("scratch", 8'(ADDR_SCRATCH_ONE + i), 8'(8'h3c ^ i));
    complete_run();
  end
endmodule

// ==== sfr_if.sv ====
`timescale 1ns/1ps
interface sfr_if;
  logic [7:0] addr;
  logic wr;
  logic rd;
  logic bit_wr;
  logic [2:0] bit_sel;
  logic bit_val;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport device (input addr, wr, rd, bit_wr, bit_sel, bit_val, wdata, output rdata);
  modport core (output addr, wr, rd, bit_wr, bit_sel, bit_val, wdata, input rdata);
endinterface
